// ---- poc_params.svh ----
`ifndef POC_PARAMS_SVH
`define POC_PARAMS_SVH

// Register byte addresses on the plain register port.
`define POC_ADDR_CFG 8'h00
`define POC_ADDR_P2CFG 8'hF7
`define POC_ADDR_P2_DATA 8'h02
`define POC_ADDR_P4_DATA 8'h04
`define POC_ADDR_P5_DATA 8'h05
`define POC_ADDR_P6_DATA 8'h06
`define POC_ADDR_P2_DIR 8'hF6
`define POC_ADDR_P4_DIR 8'h24
`define POC_ADDR_P5_DIR 8'h25
`define POC_ADDR_P6_DIR 8'h26

// Field positions in the port drive and comparator configuration register.
`define POC_CFG_SPARE_HI 7
`define POC_CFG_SPARE_LO 6
`define POC_CFG_CMP1 5
`define POC_CFG_CMP2 4
`define POC_CFG_TEST 3
`define POC_CFG_DRV6 2
`define POC_CFG_DRV5 1
`define POC_CFG_DRV4 0
`define POC_P2CFG_DRV 0

// Reset values.
`define POC_DIR_RST 8'hFF
`define POC_OUT_RST 8'h00
`define POC_DRV_RST 3'h7
`define POC_P2DRV_RST 1'b1
`define POC_SPARE_RST 2'h0

// Fixed read values.
`define POC_DRV_READ 3'h7
`define POC_P2CFG_READ 8'hFF
`define POC_P2DIR_READ 8'hFF
`define POC_UNMAPPED_READ 8'h00

// Line masks.
`define POC_PAD_MASK 8'h08
`define POC_P5_FIXED_IN 8'h0C
`define POC_CMP1_MASK 8'h03
`define POC_CMP2_MASK 8'h0C
`define POC_NO_LINES 8'h00

`endif

// ---- poc_pkg.sv ----
package poc_pkg;

  // Index of each port in the packed storage arrays.
  typedef enum logic [1:0] {
    POC_P2 = 2'h0,
    POC_P4 = 2'h1,
    POC_P5 = 2'h2,
    POC_P6 = 2'h3
  } poc_port_t;

  // Complete state of the configuration block.
  typedef struct packed {
    logic [1:0] spare;
    logic cmp1_analog;
    logic cmp2_analog;
    logic test_strobe;
    logic [2:0] drv;
    logic p2_drv;
    logic [3:0][7:0] out;
    logic [3:0][7:0] dir;
    logic [7:0] rdata;
    logic test_meta;
    logic test_sync;
  } poc_state_t;

endpackage

// ---- poc_port_config.sv ----
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "poc_params.svh"

module poc_port_config
  import poc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port2_pin_in,
  output logic [7:0] port2_pin_out,
  output logic [7:0] port2_pin_oe,
  input wire logic [7:0] port4_pin_in,
  output logic [7:0] port4_pin_out,
  output logic [7:0] port4_pin_oe,
  input wire logic [7:0] port5_pin_in,
  output logic [7:0] port5_pin_out,
  output logic [7:0] port5_pin_oe,
  input wire logic [7:0] port6_pin_in,
  output logic [7:0] port6_pin_out,
  output logic [7:0] port6_pin_oe,
  input wire logic test_mode_pin,
  output logic strobe_enable,
  output logic comparator1_pin_mode,
  output logic comparator2_pin_mode
);

  ////////////////////////////////////////////////////////////////////////////

  poc_state_t st_reg; // All registered state of the block.
  poc_state_t st_next; // Its next value.

  logic [3:0][7:0] pin_in_all; // Pins of all ports, by port index.
  logic [3:0][7:0] pin_out_all; // Pin levels of all ports.
  logic [3:0][7:0] pin_oe_all; // Pin enables of all ports.
  logic [3:0][7:0] line_in_all; // Effective direction, 1 is input.
  logic [3:0][7:0] pp_all; // Push-pull select per line.
  logic [3:0][7:0] own_all; // Lines that always read their output store.
  logic [3:0][7:0] analog_all; // Lines handed to a comparator.
  logic [3:0][7:0] read_all; // Read value per port.
  logic [7:0] p5_forced_in; // Port 5 lines held as inputs.
  logic [7:0] p5_analog; // Port 5 lines in analog use.
  logic [7:0] cfg_read; // Read view of the drive and comparator config.

  assign pin_in_all[POC_P2] = port2_pin_in;
  assign pin_in_all[POC_P4] = port4_pin_in;
  assign pin_in_all[POC_P5] = port5_pin_in;
  assign pin_in_all[POC_P6] = port6_pin_in;

  assign port2_pin_out = pin_out_all[POC_P2];
  assign port4_pin_out = pin_out_all[POC_P4];
  assign port5_pin_out = pin_out_all[POC_P5];
  assign port6_pin_out = pin_out_all[POC_P6];
  assign port2_pin_oe = pin_oe_all[POC_P2];
  assign port4_pin_oe = pin_oe_all[POC_P4];
  assign port5_pin_oe = pin_oe_all[POC_P5];
  assign port6_pin_oe = pin_oe_all[POC_P6];

  ////////////////////////////////////////////////////////////////////////////

  // Comparator pin pairs: analog mode forces both pins to inputs.
  // Port 5 lines 2 and 3 are inputs regardless of their direction bits.
  assign p5_analog = (st_reg.cmp1_analog ? `POC_CMP1_MASK : `POC_NO_LINES) |
                     (st_reg.cmp2_analog ? `POC_CMP2_MASK : `POC_NO_LINES);
  assign p5_forced_in = `POC_P5_FIXED_IN | p5_analog;

  // Direction bits: 1 is input, 0 is output.
  assign line_in_all[POC_P2] = st_reg.dir[POC_P2];
  assign line_in_all[POC_P4] = st_reg.dir[POC_P4];
  assign line_in_all[POC_P5] = st_reg.dir[POC_P5] | p5_forced_in;
  assign line_in_all[POC_P6] = st_reg.dir[POC_P6];

  // Drive selects; the current pad is excluded from push-pull drive.
  assign pp_all[POC_P2] = {8{st_reg.p2_drv}};
  assign pp_all[POC_P4] = {8{st_reg.drv[`POC_CFG_DRV4]}} & ~`POC_PAD_MASK;
  assign pp_all[POC_P5] = {8{st_reg.drv[`POC_CFG_DRV5]}};
  assign pp_all[POC_P6] = {8{st_reg.drv[`POC_CFG_DRV6]}};

  // The current pad has no input path, so reads show its stored value.
  assign own_all[POC_P2] = `POC_NO_LINES;
  assign own_all[POC_P4] = `POC_PAD_MASK;
  assign own_all[POC_P5] = `POC_NO_LINES;
  assign own_all[POC_P6] = `POC_NO_LINES;

  // Analog lines read as zero, so software sees no stale digital level.
  assign analog_all[POC_P2] = `POC_NO_LINES;
  assign analog_all[POC_P4] = `POC_NO_LINES;
  assign analog_all[POC_P5] = p5_analog;
  assign analog_all[POC_P6] = `POC_NO_LINES;

  // One pad controller per port.
  for (genvar p = 0; p < 4; p++) begin : g_port
    poc_port_pads #(
      .PORT_W(8)
    ) u_pads (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin_in(pin_in_all[p]),
      .out_val(st_reg.out[p]),
      .line_is_input(line_in_all[p]),
      .push_pull(pp_all[p]),
      .read_own(own_all[p]),
      .analog(analog_all[p]),
      .pin_out(pin_out_all[p]),
      .pin_oe(pin_oe_all[p]),
      .read_val(read_all[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////

  // Drive select bits are write-only and always read back as ones.
  // Software must therefore never read-modify-write this register.
  assign cfg_read = {st_reg.spare, st_reg.cmp1_analog, st_reg.cmp2_analog,
                     st_reg.test_strobe, `POC_DRV_READ};

  // Next state: register writes, read capture and test pin sync.
  always_comb begin
    st_next = st_reg;
    // Read data stand for exactly one cycle after the read strobe.
    st_next.rdata = `POC_UNMAPPED_READ;
    st_next.test_meta = test_mode_pin;
    st_next.test_sync = st_reg.test_meta;
    if (reg_wr) begin
      case (reg_addr)
        `POC_ADDR_CFG: begin
          st_next.spare = reg_wdata[`POC_CFG_SPARE_HI:`POC_CFG_SPARE_LO];
          st_next.cmp1_analog = reg_wdata[`POC_CFG_CMP1];
          st_next.cmp2_analog = reg_wdata[`POC_CFG_CMP2];
          st_next.test_strobe = reg_wdata[`POC_CFG_TEST];
          st_next.drv = reg_wdata[`POC_CFG_DRV6:`POC_CFG_DRV4];
        end
        `POC_ADDR_P2CFG: begin
          // Only bit 0 is stored; the rest ignore writes.
          st_next.p2_drv = reg_wdata[`POC_P2CFG_DRV];
        end
        // Data writes always land in output storage, even for inputs.
        `POC_ADDR_P2_DATA: begin
          st_next.out[POC_P2] = reg_wdata;
        end
        `POC_ADDR_P4_DATA: begin
          st_next.out[POC_P4] = reg_wdata;
        end
        `POC_ADDR_P5_DATA: begin
          st_next.out[POC_P5] = reg_wdata;
        end
        `POC_ADDR_P6_DATA: begin
          st_next.out[POC_P6] = reg_wdata;
        end
        `POC_ADDR_P2_DIR: begin
          st_next.dir[POC_P2] = reg_wdata;
        end
        `POC_ADDR_P4_DIR: begin
          // Bit 3 here selects between driving and tristating the pad.
          st_next.dir[POC_P4] = reg_wdata;
        end
        `POC_ADDR_P5_DIR: begin
          st_next.dir[POC_P5] = reg_wdata;
        end
        `POC_ADDR_P6_DIR: begin
          st_next.dir[POC_P6] = reg_wdata;
        end
        default: begin
          // Unmapped writes are dropped.
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `POC_ADDR_CFG: begin
          st_next.rdata = cfg_read;
        end
        `POC_ADDR_P2CFG: begin
          st_next.rdata = `POC_P2CFG_READ;
        end
        `POC_ADDR_P2_DATA: begin
          st_next.rdata = read_all[POC_P2];
        end
        `POC_ADDR_P4_DATA: begin
          st_next.rdata = read_all[POC_P4];
        end
        `POC_ADDR_P5_DATA: begin
          st_next.rdata = read_all[POC_P5];
        end
        `POC_ADDR_P6_DATA: begin
          st_next.rdata = read_all[POC_P6];
        end
        `POC_ADDR_P2_DIR: begin
          // Port 2 direction is write-only.
          st_next.rdata = `POC_P2DIR_READ;
        end
        `POC_ADDR_P4_DIR: begin
          st_next.rdata = st_reg.dir[POC_P4];
        end
        `POC_ADDR_P5_DIR: begin
          st_next.rdata = st_reg.dir[POC_P5];
        end
        `POC_ADDR_P6_DIR: begin
          st_next.rdata = st_reg.dir[POC_P6];
        end
        default: begin
          st_next.rdata = `POC_UNMAPPED_READ;
        end
      endcase
    end
  end

  // State register; directions reset to input, which also tristates the pad.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.spare <= `POC_SPARE_RST;
      st_reg.drv <= `POC_DRV_RST;
      st_reg.p2_drv <= `POC_P2DRV_RST;
      st_reg.dir <= {4{`POC_DIR_RST}};
      st_reg.out <= {4{`POC_OUT_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  // The strobe enable bit is inert unless the test mode pin is high.
  assign strobe_enable = st_reg.test_strobe && st_reg.test_sync;
  assign comparator1_pin_mode = st_reg.cmp1_analog;
  assign comparator2_pin_mode = st_reg.cmp2_analog;

  ////////////////////////////////////////////////////////////////////////////

  default clocking poc_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Register access steps used by the properties below.
  sequence s_wr_cfg;
    reg_wr && reg_addr == `POC_ADDR_CFG;
  endsequence
  sequence s_rd_cfg;
    reg_rd && reg_addr == `POC_ADDR_CFG;
  endsequence
  sequence s_wr_p2_data;
    reg_wr && reg_addr == `POC_ADDR_P2_DATA;
  endsequence
  sequence s_p2_to_output;
    reg_wr && reg_addr == `POC_ADDR_P2_DIR && reg_wdata == 8'h00;
  endsequence
  sequence s_rd_p2_data;
    reg_rd && reg_addr == `POC_ADDR_P2_DATA;
  endsequence

  AST_INPUT_UNDRIVEN: assert property ((port2_pin_oe & st_reg.dir[POC_P2]) == 8'h00) else $error("Input line is driven.");
  AST_OUT_READBACK: assert property (s_wr_p2_data ##1 s_p2_to_output ##1 s_rd_p2_data |=> reg_rdata == $past(reg_wdata, 3)) else $error("Stored output not read back.");
  AST_CMP1_ANALOG: assert property (comparator1_pin_mode |-> (port5_pin_oe & `POC_CMP1_MASK) == 8'h00) else $error("Comparator one pins driven.");
  AST_CMP2_ANALOG: assert property (s_wr_cfg ##0 reg_wdata[`POC_CFG_CMP2] |=> comparator2_pin_mode && (port5_pin_oe & `POC_CMP2_MASK) == 8'h00) else $error("Comparator two not analog.");
  AST_SPARE_RW: assert property (s_wr_cfg ##1 s_rd_cfg |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 2)) else $error("Spare bits lost.");
  AST_STROBE_GATE: assert property (strobe_enable |-> $past(test_mode_pin, 2) && cfg_read[`POC_CFG_TEST]) else $error("Strobe enable outside test mode.");
  AST_CFG_READ_ONES: assert property (s_rd_cfg |=> reg_rdata[2:0] == 3'h7) else $error("Drive bits not read as ones.");
  AST_OPEN_DRAIN: assert property (s_wr_cfg ##0 !reg_wdata[`POC_CFG_DRV6] |=> ((port6_pin_oe & port6_pin_out) == 8'h00)[*2]) else $error("Open drain line drove high.");
  AST_PAD_NOT_PP: assert property (port4_pin_oe[3] |-> !port4_pin_out[3]) else $error("Current pad drove high.");
  AST_P2CFG_READ: assert property (reg_rd && reg_addr == `POC_ADDR_P2CFG |=> reg_rdata == 8'hFF) else $error("Port 2 config not all ones.");
  AST_PAD_READ: assert property (reg_rd && reg_addr == `POC_ADDR_P4_DATA |=> reg_rdata[3] == $past(st_reg.out[POC_P4][3])) else $error("Current pad read wrong.");
  AST_P2_PUSH_PULL: assert property (st_reg.p2_drv && !st_reg.dir[POC_P2][0] |-> port2_pin_oe[0]) else $error("Port 2 push-pull not driving.");

endmodule

// ---- poc_port_pads.sv ----
`timescale 1ns/1ps

// One port's pad control: input synchroniser, drive and read selection.
module poc_port_pads #(
  parameter int PORT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [PORT_W-1:0] pin_in,
  input wire logic [PORT_W-1:0] out_val,
  input wire logic [PORT_W-1:0] line_is_input,
  input wire logic [PORT_W-1:0] push_pull,
  input wire logic [PORT_W-1:0] read_own,
  input wire logic [PORT_W-1:0] analog,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe,
  output logic [PORT_W-1:0] read_val
);

  // The register map packs eight lines per port, so nothing else fits.
  if (PORT_W != 8) begin : g_bad_width
    $error("poc_port_pads supports only PORT_W of 8.");
  end

  // Two stage synchroniser; meta is read only by sync.
  typedef struct packed {
    logic [PORT_W-1:0] meta;
    logic [PORT_W-1:0] sync;
  } poc_sync_t;

  poc_sync_t st_reg; // Registered synchroniser state.
  poc_sync_t st_next; // Next value of the synchroniser.

  // Shift the pins through both stages.
  always_comb begin
    st_next = st_reg;
    st_next.meta = pin_in;
    st_next.sync = st_reg.meta;
  end

  // Register the synchroniser state.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Per line drive and read selection.
  for (genvar i = 0; i < PORT_W; i++) begin : g_line
    // The pin level always follows output storage; only the enable changes.
    assign pin_out[i] = out_val[i];
    // Open drain lines pull low on 0 and release on 1.
    assign pin_oe[i] = !line_is_input[i] && (push_pull[i] || !out_val[i]);
    // Input lines show the pin unless read_own, outputs show stored data; analog reads 0.
    assign read_val[i] = (read_own[i] || !line_is_input[i]) ? out_val[i] :
                         (st_reg.sync[i] && !analog[i]);
  end

endmodule

// ---- tb_poc_port_config.sv ----
`timescale 1ns/1ps

// Self-checking bench for the port drive and direction configuration block.
module tb_poc_port_config;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals.
  logic sys_clk;
  logic rst_b;
  logic reg_wr;
  logic reg_rd;
  logic test_mode_pin;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] p2_in, p4_in, p5_in, p6_in;
  logic [7:0] p2_out, p4_out, p5_out, p6_out;
  logic [7:0] p2_oe, p4_oe, p5_oe, p6_oe;
  logic strobe_enable;
  logic cmp1_mode;
  logic cmp2_mode;
  int fail_count;
  int checks_done;

  // Each row is address, write data and the value a read should return.
  logic [23:0] rows [15] = '{
    24'h00_F8_FF, 24'h00_00_07, 24'h00_40_47, 24'h00_80_87,
    24'hF7_00_FF, 24'h24_5A_5A, 24'h25_A5_A5, 24'h26_3C_3C,
    24'hF6_FF_FF, 24'h10_55_00, 24'h24_FF_FF, 24'h25_FF_FF,
    24'h26_FF_FF, 24'h00_07_07, 24'hF7_01_FF};

  poc_port_config i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .port2_pin_in(p2_in), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe),
    .port4_pin_in(p4_in), .port4_pin_out(p4_out), .port4_pin_oe(p4_oe),
    .port5_pin_in(p5_in), .port5_pin_out(p5_out), .port5_pin_oe(p5_oe),
    .port6_pin_in(p6_in), .port6_pin_out(p6_out), .port6_pin_oe(p6_oe),
    .test_mode_pin(test_mode_pin), .strobe_enable(strobe_enable),
    .comparator1_pin_mode(cmp1_mode), .comparator2_pin_mode(cmp2_mode));

  ////////////////////////////////////////////////////////////////////////////
  // The 125 MHz core clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write; returns 1 ns after the taking edge so state has landed.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data is only valid in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Reset defaults of pad enables, mode outputs, config and direction reads; output storage is not checked.
  task automatic rst_chk;
    chk(p2_oe | p4_oe | p5_oe | p6_oe, 8'h00);
    chk({5'h00, strobe_enable, cmp1_mode, cmp2_mode}, 8'h00);
    rd(8'h00, 8'h07);
    rd(8'hF7, 8'hFF);
    rd(8'h24, 8'hFF);
    rd(8'h25, 8'hFF);
    rd(8'h26, 8'hFF);
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude;
    if (fail_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hung run short; counts as a mismatch.
  initial begin
    #400000;
    fail_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence. The configuration register is only ever written whole,
  // never read, changed and written back, since its drive bits read as 1.
  initial begin
    fail_count = 0;
    checks_done = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    test_mode_pin = 1'b0;
    p2_in = 8'h00;
    p4_in = 8'h00;
    p5_in = 8'h00;
    p6_in = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rst_chk();
    for (int i = 0; i < 15; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    // Data written to input lines is stored but neither driven nor read.
    @(posedge sys_clk);
    p2_in <= 8'h3C;
    wr(8'h02, 8'hA5);
    chk(p2_oe, 8'h00);
    repeat (3) @(posedge sys_clk);
    rd(8'h02, 8'h3C);
    wr(8'hF6, 8'h00);
    chk(p2_oe, 8'hFF);
    chk(p2_out, 8'hA5);
    rd(8'h02, 8'hA5);
    wr(8'hF7, 8'h00);
    chk(p2_oe, 8'h5A);
    // Back-to-back strobes: make inputs, store, switch to output, read,
    // then a config write and read; read data stand for one cycle only.
    @(posedge sys_clk);
    reg_addr <= 8'hF6;
    reg_wdata <= 8'hFF;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_addr <= 8'h02;
    reg_wdata <= 8'h3C;
    @(posedge sys_clk);
    reg_addr <= 8'hF6;
    reg_wdata <= 8'h00;
    @(posedge sys_clk);
    reg_addr <= 8'h02;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_addr <= 8'h00;
    reg_wdata <= 8'hC7;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h3C);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    #1;
    chk(reg_rdata, 8'h00);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'hC7);
    // The current pad is never push-pull and always reads its storage.
    wr(8'h24, 8'h00);
    wr(8'h04, 8'hFF);
    chk(p4_oe, 8'hF7);
    chk(p4_out, 8'hFF);
    rd(8'h04, 8'hFF);
    wr(8'h04, 8'hF7);
    chk(p4_oe, 8'hFF);
    wr(8'h24, 8'h08);
    chk(p4_oe, 8'hF7);
    rd(8'h04, 8'hF7);
    wr(8'h00, 8'h06);
    chk(p4_oe, 8'h00);
    // Open-drain selects for ports 5 and 6, then comparator pin pairs.
    wr(8'h00, 8'h01);
    wr(8'h26, 8'h00);
    wr(8'h06, 8'h0F);
    chk(p6_oe, 8'hF0);
    chk(p6_out, 8'h0F);
    @(posedge sys_clk);
    p5_in <= 8'hFF;
    wr(8'h25, 8'h00);
    wr(8'h05, 8'h0F);
    chk(p5_oe, 8'hF0);
    chk(p5_out, 8'h0F);
    repeat (3) @(posedge sys_clk);
    rd(8'h05, 8'h0F);
    wr(8'h00, 8'h37);
    chk({6'h00, cmp1_mode, cmp2_mode}, 8'h03);
    chk(p5_oe, 8'hF0);
    chk(p6_oe, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'h17);
    chk({6'h00, cmp1_mode, cmp2_mode}, 8'h01);
    chk(p5_oe, 8'hF3);
    wr(8'h00, 8'h27);
    chk({6'h00, cmp1_mode, cmp2_mode}, 8'h02);
    chk(p5_oe, 8'hF0);
    // The strobe enable follows bit 3 only while the test pin is high.
    wr(8'h00, 8'h0F);
    chk({7'h00, strobe_enable}, 8'h00);
    @(posedge sys_clk);
    test_mode_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({7'h00, strobe_enable}, 8'h01);
    wr(8'h00, 8'h07);
    chk({7'h00, strobe_enable}, 8'h00);
    // A second reset in mid-run restores every default.
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rst_chk();
    conclude();
  end

endmodule
